/* hw/aof_pkg.sv */
// Constants, register map and carrier types for the output format and trim block
package aof_pkg;

  // ----------------------------------------------------------------
  // Data path geometry
  // ----------------------------------------------------------------
  localparam int DW         = 11;   // Bits per output word
  localparam int NCH        = 2;    // Channel A = 0, channel B = 1
  localparam int NPAIR      = 6;    // Differential data pairs per channel
  localparam int LAT_NORM   = 14;   // Sample clocks, full processing path
  localparam int LAT_LOW    = 10;   // Sample clocks, bypass path
  localparam int LINE_DEPTH = 14;   // Delay line entries per channel
  localparam int ACC_W      = 41;   // Offset integrator width
  localparam int OFS_W      = 5;    // Offset estimate width
  localparam int OFS_LIM    = 10;   // Estimate limit in codes, about 10 mV
  localparam int GAIN_FRAC  = 14;   // Fraction bits of the gain factor
  localparam int PIN_W      = 31;   // Width of the synchronised pin bundle

  // ----------------------------------------------------------------
  // Overdrive codes
  // ----------------------------------------------------------------
  localparam logic [DW-1:0] POS_FS_BIN  = 11'h7ff;
  localparam logic [DW-1:0] POS_FS_TWOS = 11'h3ff;
  localparam logic [DW-1:0] NEG_FS_BIN  = 11'h000;
  localparam logic [DW-1:0] NEG_FS_TWOS = 11'h400;

  // ----------------------------------------------------------------
  // Register byte offsets (bus address bits 7:0)
  // ----------------------------------------------------------------
  localparam logic [7:0] OFS_CTRL   = 8'h00;
  localparam logic [7:0] OFS_DCTRL  = 8'h04;
  localparam logic [7:0] OFS_GAIN   = 8'h08;
  localparam logic [7:0] OFS_DRIVE  = 8'h0c;
  localparam logic [7:0] OFS_STATUS = 8'h10;

  // ----------------------------------------------------------------
  // Power state codes
  // ----------------------------------------------------------------
  localparam logic [2:0] PM_A_OFF  = 3'h1;
  localparam logic [2:0] PM_B_OFF  = 3'h2;
  localparam logic [2:0] PM_AB_OFF = 3'h3;
  localparam logic [2:0] PM_DOWN   = 3'h4;
  localparam logic [2:0] PM_MUX    = 3'h7;

  // Drive current select codes
  localparam logic [1:0] CUR_3P5  = 2'h0;
  localparam logic [1:0] CUR_2P5  = 2'h1;
  localparam logic [1:0] CUR_4P5  = 2'h2;
  localparam logic [1:0] CUR_1P75 = 2'h3;

  // ----------------------------------------------------------------
  // Gain and loop tables
  // ----------------------------------------------------------------
  localparam logic [3:0]  GAIN_MAX_CODE = 4'ha;
  localparam logic [14:0] GAIN_ONE      = 15'h4000;
  localparam logic [14:0] GAIN_TABLE [0:10] = '{
    15'h4000, 15'h405f, 15'h40be, 15'h411e, 15'h417e, 15'h41de,
    15'h4240, 15'h42a2, 15'h4304, 15'h4367, 15'h43cb};
  localparam logic [4:0] TC_SHIFT [0:7] = '{
    5'h1b, 5'h1a, 5'h19, 5'h18, 5'h1c, 5'h1d, 5'h1b, 5'h1b};

  // ----------------------------------------------------------------
  // Register layouts and reset values
  // ----------------------------------------------------------------
  typedef struct packed {
    logic [2:0] power_code;
    logic       use_pins;
    logic       low_latency;
    logic       fmt_binary;
    logic       iface_lvds;
  } aof_ctrl_t;

  typedef struct packed {
    logic [2:0] dc_trim_time_const;
    logic       freeze;
    logic       ofs_en;
  } aof_dctrl_t;

  typedef struct packed {
    logic       clock_drive_level;
    logic       data_drive_level;
    logic [2:0] termination;
    logic       current_double;
    logic [1:0] lvds_current;
  } aof_drive_t;

  typedef struct packed {
    logic [NPAIR-1:0] a;
    logic [NPAIR-1:0] b;
  } aof_lvds_t;

  localparam aof_ctrl_t  CTRL_RST  = 7'h00;
  localparam aof_dctrl_t DCTRL_RST = 5'h00;
  localparam aof_drive_t DRIVE_RST = 8'h00;

endpackage

/* hw/aof_core.sv */
// Output formatting, offset and gain trim, CMOS and DDR output stage with bus registers
//
// Summary of operation
// R1: DDR mode drives each channel's bits plus one shared clock on differential pairs.
// R2: Each DDR pair carries two successive bits per sample clock period.
// R3: Odd bits launch at forwarded clock rise, even bits at its fall.
// R4: Receiver samples on both forwarded clock edges to recover every bit.
// R5: Drive current defaults to 3.5 mA; 2.5, 4.5, 1.75 mA selectable.
// R6: Doubling bit doubles drive current for data and clock pairs.
// R7: Three termination legs, any combination, eight settings.
// R8: Format is two's complement or straight binary, by bit or pin.
// R9: Positive overrange gives 0x7FF binary, 0x3FF two's complement.
// R10: Negative overrange gives 0x000 binary, 0x400 two's complement.
// R11: Multiplexed mode only with CMOS; both channels interleave on bus B.
// R12: In multiplexed mode all channel A pins are high impedance.
// R13: Controller enables multiplexed mode only below 65 MSPS, by code or pins.
// R14: Latency 14 sample clocks, or 10 in low-latency mode.
// R15: Low-latency mode bypasses offset and gain processing.
// R16: Offset loop estimates up to about 10 mV and subtracts it.
// R17: Three-bit time constant selects loop length 2^24 to 2^29.
// R18: Freeze stops estimate updates and keeps applying the last one.
// R19: Offset correction is disabled after reset.
// R20: Four-bit gain trim gives 0 to 0.5 dB in 0.05 dB steps, both channels.
// R21: Separate bits raise CMOS data and clock drive strength.
// R22: Power-state code 111 selects multiplexed output mode.
// R23: Gain codes above 1010 mean no correction; results saturate at full scale.
`timescale 1ns/10ps
`default_nettype none
module aof_core
  import aof_pkg::*;
(
  input  wire logic            hclk,
  input  wire logic            hresetn,
  input  wire logic            hsel,
  input  wire logic [31:0]     haddr,
  input  wire logic [1:0]      htrans,
  input  wire logic            hwrite,
  input  wire logic [2:0]      hsize,
  input  wire logic [31:0]     hwdata,
  input  wire logic            hready,
  output logic      [31:0]     hrdata,
  output logic                 hreadyout,
  output logic                 hresp,
  input  wire logic            sample_clk_pin,
  input  wire logic [DW-1:0]   raw_a,
  input  wire logic [DW-1:0]   raw_b,
  input  wire logic [NCH-1:0]  over_pos,
  input  wire logic [NCH-1:0]  over_neg,
  input  wire logic            serial_enable_pin,
  input  wire logic            control_pin_one,
  input  wire logic            control_pin_two,
  input  wire logic            control_pin_three,
  output logic      [DW-1:0]   channel_a_bus,
  output logic                 channel_a_oe,
  output logic      [DW-1:0]   channel_b_bus,
  output logic                 channel_b_oe,
  output logic                 cmos_clock_out,
  output aof_lvds_t            lvds_pos,
  output aof_lvds_t            lvds_neg,
  output logic                 forwarded_clock_pos,
  output logic                 forwarded_clock_neg,
  output logic                 lvds_oe,
  output logic      [1:0]      lvds_current,
  output logic                 current_double,
  output logic      [2:0]      termination,
  output logic                 data_drive_level,
  output logic                 clock_drive_level
);

  default clocking cb @(posedge hclk);
  endclocking
  default disable iff (!hresetn);

  // ----------------------------------------------------------------
  // Local constants and helpers
  // ----------------------------------------------------------------
  localparam logic signed [ACC_W-1:0] LIM_HI = ACC_W'(OFS_LIM);
  localparam logic signed [ACC_W-1:0] LIM_LO = -LIM_HI;
  localparam logic signed [27:0]      SAT_HI = 28'h00003ff;
  localparam logic signed [27:0]      SAT_LO = 28'hffffc00;

  // Bits launched on the rising clock edge: 1, 3, 5 ...
  function automatic logic [NPAIR-1:0] odd_bits(input logic [DW-1:0] w);
    logic [NPAIR-1:0] r;
    r = '0;
    for (int k = 0; k < NPAIR; k++) begin
      if (2 * k + 1 < DW) begin
        r[k] = w[2*k+1];
      end
    end
    return r;
  endfunction

  // Bits launched on the falling clock edge: 0, 2, 4 ...
  function automatic logic [NPAIR-1:0] even_bits(input logic [DW-1:0] w);
    logic [NPAIR-1:0] r;
    r = '0;
    for (int k = 0; k < NPAIR; k++) begin
      if (2 * k < DW) begin
        r[k] = w[2*k];
      end
    end
    return r;
  endfunction

  // ----------------------------------------------------------------
  // Pin synchronisers and sample clock edge detect
  // ----------------------------------------------------------------
  logic [PIN_W-1:0] pin_meta;
  logic [PIN_W-1:0] pin_sync;
  logic             sclk_prev;
  logic             rise;
  logic             fall;

  // Two stages before anything reads the pins
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      pin_meta <= '0;
      pin_sync <= '0;
    end else begin
      pin_meta <= {sample_clk_pin, raw_b, raw_a, over_neg, over_pos,
                   serial_enable_pin, control_pin_one, control_pin_two, control_pin_three};
      pin_sync <= pin_meta;
    end
  end

  // Previous sampled level of the sample clock
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      sclk_prev <= 1'b0;
    end else begin
      sclk_prev <= pin_sync[30];
    end
  end

  assign rise = pin_sync[30] & ~sclk_prev;
  assign fall = ~pin_sync[30] & sclk_prev;

  logic [DW-1:0]  raw_s [NCH];
  logic [NCH-1:0] ovp_s;
  logic [NCH-1:0] ovn_s;
  logic [2:0]     pin_code;
  logic           sen_s;

  assign raw_s[0] = pin_sync[18:8];
  assign raw_s[1] = pin_sync[29:19];
  assign ovn_s    = pin_sync[7:6];
  assign ovp_s    = pin_sync[5:4];
  assign sen_s    = pin_sync[3];
  assign pin_code = pin_sync[2:0];

  // ----------------------------------------------------------------
  // Register bus slave
  // ----------------------------------------------------------------
  aof_ctrl_t   ctrl;
  aof_dctrl_t  dctrl;
  aof_drive_t  drive;
  logic [3:0]  gain_code;
  logic        ph_valid;
  logic        ph_write;
  logic [7:0]  ph_addr;
  logic        drive_written;
  logic [31:0] next_rdata;
  logic signed [OFS_W-1:0] est [NCH];
  logic [2:0]  eff_power;
  logic        eff_binary;
  logic        mux_mode;

  // Address phase capture; zero wait states
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      ph_valid  <= 1'b0;
      ph_write  <= 1'b0;
      ph_addr   <= 8'h00;
      hreadyout <= 1'b0;
      hresp     <= 1'b0;
    end else begin
      hreadyout <= 1'b1;
      hresp     <= 1'b0;
      if (hready) begin
        ph_valid <= hsel & htrans[1];
        ph_write <= hwrite;
        ph_addr  <= haddr[7:0];
      end
    end
  end

  // Register writes in the data phase
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      ctrl          <= CTRL_RST;
      dctrl         <= DCTRL_RST;   // R19
      drive         <= DRIVE_RST;   // R5
      gain_code     <= 4'h0;
      drive_written <= 1'b0;
    end else if (ph_valid && ph_write) begin
      case (ph_addr)
        OFS_CTRL:  ctrl      <= hwdata[6:0];
        OFS_DCTRL: dctrl     <= hwdata[4:0];
        OFS_GAIN:  gain_code <= hwdata[3:0];   // R20
        OFS_DRIVE: begin
          drive         <= hwdata[7:0];   // R5 R6 R7 R21
          drive_written <= 1'b1;
        end
        default: ;
      endcase
    end
  end

  // Read mux, including live offset estimates and effective mode
  always_comb begin
    next_rdata = 32'h0000_0000;
    case (haddr[7:0])
      OFS_CTRL:   next_rdata[6:0] = ctrl;
      OFS_DCTRL:  next_rdata[4:0] = dctrl;
      OFS_GAIN:   next_rdata[3:0] = gain_code;
      OFS_DRIVE:  next_rdata[7:0] = drive;
      OFS_STATUS: begin
        next_rdata[4:0]   = est[0];
        next_rdata[12:8]  = est[1];
        next_rdata[16]    = mux_mode;
        next_rdata[17]    = eff_binary;
        next_rdata[22:20] = eff_power;
      end
      default: next_rdata = 32'h0000_0000;
    endcase
  end

  // Read data is loaded at the address phase edge
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      hrdata <= 32'h0000_0000;
    end else if (hready && hsel && htrans[1] && !hwrite) begin
      hrdata <= next_rdata;
    end
  end

  assign lvds_current      = drive.lvds_current;      // R5
  assign current_double    = drive.current_double;    // R6
  assign termination       = drive.termination;       // R7
  assign data_drive_level  = drive.data_drive_level;  // R21
  assign clock_drive_level = drive.clock_drive_level; // R21

  // ----------------------------------------------------------------
  // Effective configuration: register or parallel pins
  // ----------------------------------------------------------------
  assign eff_power  = ctrl.use_pins ? pin_code : ctrl.power_code;
  assign eff_binary = ctrl.use_pins ? sen_s : ctrl.fmt_binary;   // R8
  assign mux_mode   = !ctrl.iface_lvds && (eff_power == PM_MUX); // R11 R22

  logic [14:0] gain_factor;
  logic [4:0]  loop_shift;

  // Codes above the top step fall back to unity gain
  assign gain_factor = (gain_code <= GAIN_MAX_CODE) ? GAIN_TABLE[gain_code] : GAIN_ONE; // R20 R23
  assign loop_shift  = TC_SHIFT[dctrl.dc_trim_time_const]; // R17

  // ----------------------------------------------------------------
  // Per channel trim, format and delay line
  // ----------------------------------------------------------------
  logic [DW-1:0] tap [NCH];

  for (genvar g = 0; g < NCH; g++) begin : gen_ch
    logic signed [ACC_W-1:0] acc;
    logic signed [ACC_W-1:0] next_acc;
    logic signed [ACC_W-1:0] shifted;
    logic signed [OFS_W-1:0] next_est;
    logic signed [DW:0]      err;
    logic signed [27:0]      prod;
    logic signed [27:0]      scaled;
    logic [DW-1:0]           sat;
    logic [DW-1:0]           proc;
    logic [DW-1:0]           fmt;
    logic [DW-1:0]           dline [0:LINE_DEPTH-1];

    // Sample minus current estimate
    assign err = $signed({raw_s[g][DW-1], raw_s[g]}) -
                 $signed({{(DW+1-OFS_W){est[g][OFS_W-1]}}, est[g]}); // R16
    assign next_acc = acc + {{(ACC_W-DW-1){err[DW]}}, err};
    assign shifted  = next_acc >>> loop_shift;   // R17

    // Estimate limited to the correction range
    always_comb begin
      if (shifted > LIM_HI) begin
        next_est = LIM_HI[OFS_W-1:0];
      end else if (shifted < LIM_LO) begin
        next_est = LIM_LO[OFS_W-1:0];
      end else begin
        next_est = shifted[OFS_W-1:0];
      end
    end

    // Integrating offset loop, one step per sample
    always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
        acc    <= '0;
        est[g] <= '0;
      end else if (!dctrl.ofs_en || ctrl.low_latency) begin
        acc    <= '0;   // R19
        est[g] <= '0;
      end else if (rise && !dctrl.freeze) begin   // R18
        acc    <= next_acc;
        est[g] <= next_est;
      end
    end

    // Gain trim and saturation to full scale
    assign prod   = err * $signed({1'b0, gain_factor});   // R20
    assign scaled = prod >>> GAIN_FRAC;
    assign sat    = (scaled > SAT_HI) ? SAT_HI[DW-1:0] :
                    (scaled < SAT_LO) ? SAT_LO[DW-1:0] : scaled[DW-1:0]; // R23
    assign proc   = ctrl.low_latency ? raw_s[g] : sat;   // R15

    // Number format with fixed overdrive codes
    always_comb begin
      if (ovp_s[g]) begin
        fmt = eff_binary ? POS_FS_BIN : POS_FS_TWOS;   // R9
      end else if (ovn_s[g]) begin
        fmt = eff_binary ? NEG_FS_BIN : NEG_FS_TWOS;   // R10
      end else begin
        fmt = eff_binary ? {~proc[DW-1], proc[DW-2:0]} : proc;   // R8
      end
    end

    // Delay line shifted once per sample clock
    always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
        for (int i = 0; i < LINE_DEPTH; i++) begin
          dline[i] <= '0;
        end
      end else if (rise) begin
        dline[0] <= fmt;
        for (int i = 1; i < LINE_DEPTH; i++) begin
          dline[i] <= dline[i-1];
        end
      end
    end

    assign tap[g] = ctrl.low_latency ? dline[LAT_LOW-1] : dline[LAT_NORM-1]; // R14

    chk_bypass_raw: assert property (ctrl.low_latency |-> proc == raw_s[g])   // R15
      else $error("bypass path altered the sample");
    chk_pos_over_code: assert property (rise && ovp_s[g] |=>   // R9
        dline[0] == ($past(eff_binary) ? POS_FS_BIN : POS_FS_TWOS))
      else $error("wrong positive overdrive code");
    chk_neg_over_code: assert property (rise && ovn_s[g] && !ovp_s[g] |=>   // R10
        dline[0] == ($past(eff_binary) ? NEG_FS_BIN : NEG_FS_TWOS))
      else $error("wrong negative overdrive code");
    chk_freeze_holds: assert property (dctrl.ofs_en && dctrl.freeze && $past(dctrl.freeze)   // R18
        && !ctrl.low_latency |=> $stable(est[g]))
      else $error("estimate moved while frozen");
    chk_ofs_disabled: assert property (!dctrl.ofs_en |=> est[g] == '0)   // R19
      else $error("estimate not cleared while disabled");
    chk_ofs_limit: assert property (est[g] <= OFS_LIM && est[g] >= -OFS_LIM)   // R16
      else $error("offset estimate out of range");
  end

  // ----------------------------------------------------------------
  // Output stage: CMOS buses and DDR pairs
  // ----------------------------------------------------------------
  logic [DW-1:0] word [NCH];

  // Launch words on sample clock edges
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      word[0]             <= '0;
      word[1]             <= '0;
      channel_a_bus       <= '0;
      channel_b_bus       <= '0;
      cmos_clock_out      <= 1'b0;
      forwarded_clock_pos <= 1'b0;
      forwarded_clock_neg <= 1'b1;
      lvds_pos            <= '0;
      lvds_neg            <= '1;
    end else if (rise) begin
      word[0]             <= tap[0];
      word[1]             <= tap[1];
      channel_a_bus       <= tap[0];
      channel_b_bus       <= mux_mode ? tap[0] : tap[1];   // R11
      cmos_clock_out      <= 1'b0;
      forwarded_clock_pos <= 1'b1;   // R1
      forwarded_clock_neg <= 1'b0;
      lvds_pos            <= {odd_bits(tap[0]), odd_bits(tap[1])};   // R2 R3
      lvds_neg            <= ~{odd_bits(tap[0]), odd_bits(tap[1])};
    end else if (fall) begin
      if (mux_mode) begin
        channel_b_bus <= word[1];   // R11
      end
      cmos_clock_out      <= 1'b1;
      forwarded_clock_pos <= 1'b0;
      forwarded_clock_neg <= 1'b1;
      lvds_pos            <= {even_bits(word[0]), even_bits(word[1])};   // R2 R3
      lvds_neg            <= ~{even_bits(word[0]), even_bits(word[1])};
    end
  end

  // Output enables from interface choice and power state
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      channel_a_oe <= 1'b0;
      channel_b_oe <= 1'b0;
      lvds_oe      <= 1'b0;
    end else begin
      channel_a_oe <= !ctrl.iface_lvds && !(eff_power inside
                      {PM_A_OFF, PM_AB_OFF, PM_DOWN, PM_MUX});   // R12
      channel_b_oe <= !ctrl.iface_lvds && !(eff_power inside {PM_B_OFF, PM_AB_OFF, PM_DOWN});
      lvds_oe      <= ctrl.iface_lvds && (eff_power != PM_DOWN);   // R1
    end
  end

  // ----------------------------------------------------------------
  // Checks on the output stage and configuration
  // ----------------------------------------------------------------
  chk_odd_on_rise: assert property ($rose(forwarded_clock_pos) |->   // R3
      lvds_pos.a == odd_bits(word[0]) && lvds_pos.b == odd_bits(word[1]))
    else $error("odd bits not on rising edge");
  chk_even_on_fall: assert property ($fell(forwarded_clock_pos) |->   // R2
      lvds_pos.a == even_bits(word[0]) && lvds_pos.b == even_bits(word[1]))
    else $error("even bits not on falling edge");
  chk_mux_a_off: assert property (mux_mode |=> !channel_a_oe)   // R12
    else $error("channel A driven in multiplexed mode");
  chk_mux_b_second: assert property (mux_mode && fall |=> channel_b_bus == word[1])   // R11
    else $error("channel B word missing on shared bus");
  chk_drive_default: assert property (!drive_written |-> lvds_current == CUR_3P5)   // R5
    else $error("drive current not at default");
  chk_gain_unused: assert property (gain_code > GAIN_MAX_CODE |-> gain_factor == GAIN_ONE) // R23
    else $error("unused gain code applied a gain");

  cov_mux_frame: cover property (mux_mode && rise ##[1:40] fall);
  cov_low_latency: cover property (ctrl.low_latency && rise);
  cov_freeze: cover property (dctrl.ofs_en && dctrl.freeze && rise);
  cov_ddr_pair: cover property (lvds_oe && $rose(forwarded_clock_pos) ##[1:20] $fell(forwarded_clock_pos));

endmodule
`default_nettype wire

/* tb/aof_rx_model.sv */
// Receiving logic model that captures CMOS and DDR output words
`timescale 1ns/10ps
`default_nettype none
module aof_rx_model
  import aof_pkg::*;
(
  input  wire logic          fclk,
  input  wire logic          cclk,
  input  wire aof_lvds_t     dp,
  input  wire logic [DW-1:0] bus_a,
  input  wire logic [DW-1:0] bus_b,
  output logic      [DW-1:0] ddr_a,
  output logic      [DW-1:0] cm_a,
  output logic      [DW-1:0] cm_b,
  output logic      [DW-1:0] mux_a,
  output int                 n_ddr,
  output int                 n_cm
);
  logic [DW:0] w;
  // Odd bits are taken at the forwarded clock rise
  always @(posedge fclk) begin
    #1;
    for (int k = 0; k < NPAIR; k++) w[2*k+1] = dp.a[k];
  end
  // Even bits at the fall complete the word
  always @(negedge fclk) begin
    #1;
    for (int k = 0; k < NPAIR; k++) w[2*k] = dp.a[k];
    ddr_a = w[DW-1:0];
    n_ddr++;
  end
  // First half of a multiplexed period on bus B
  always @(negedge cclk) begin
    #1;
    mux_a = bus_b;
  end
  // Both buses at the CMOS clock rise
  always @(posedge cclk) begin
    #1;
    cm_a = bus_a;
    cm_b = bus_b;
    n_cm++;
  end
endmodule
`default_nettype wire

/* tb/tb_top.sv */
// Self-checking bench for the output format and trim block
`timescale 1ns/10ps
`default_nettype none
module tb_top
  import aof_pkg::*;
;
  logic            hclk, sample_clk_pin, hreadyout, channel_a_oe, channel_b_oe, cmos_clock_out;
  logic            hresetn = 0, hwrite = 0, serial_enable_pin = 0;
  logic [1:0]      htrans = 0, over_pos = 0, over_neg = 0, lvds_current;
  logic [2:0]      pins = 0, termination;
  logic [31:0]     haddr = 0, hwdata = 0, hrdata, rd;
  logic [DW-1:0]   raw_a = 0, raw_b = 0, ra, rb, ddr_a, cm_a, cm_b, mux_a;
  logic [DW-1:0]   channel_a_bus, channel_b_bus;
  logic            forwarded_clock_pos, lvds_oe, current_double;
  logic            data_drive_level, clock_drive_level;
  logic [7:0]      d;
  logic [12:0]     q[$], e, g;
  aof_lvds_t       lvds_pos;
  int              err_total = 0, checked = 0, n_ddr, n_cm;
  integer          seed = 32'h36fe;
  aof_core dut_u (.hclk, .hresetn, .hsel(1'b1), .haddr, .htrans, .hwrite, .hsize(3'h2),
    .hwdata, .hready(hreadyout), .hrdata, .hreadyout, .hresp(), .sample_clk_pin, .raw_a,
    .raw_b, .over_pos, .over_neg, .serial_enable_pin, .control_pin_one(pins[2]),
    .control_pin_two(pins[1]), .control_pin_three(pins[0]), .channel_a_bus, .channel_a_oe,
    .channel_b_bus, .channel_b_oe, .cmos_clock_out, .lvds_pos, .lvds_neg(),
    .forwarded_clock_pos, .forwarded_clock_neg(), .lvds_oe, .lvds_current, .current_double,
    .termination, .data_drive_level, .clock_drive_level);
  aof_rx_model rx_u (.fclk(forwarded_clock_pos), .cclk(cmos_clock_out), .dp(lvds_pos),
    .bus_a(channel_a_bus), .bus_b(channel_b_bus), .ddr_a, .cm_a, .cm_b, .mux_a, .n_ddr, .n_cm);
  // System clock
  initial begin
    hclk = 0;
    forever #4 hclk = ~hclk;
  end
  // Sample clock of 64 ns, slow enough for mux mode
  initial begin
    sample_clk_pin = 0;
    #3;
    forever #32 sample_clk_pin = ~sample_clk_pin;
  end
  task automatic give_verdict;
    if (err_total == 0 && checked > 0) $display("STATUS OK");
    else $display("STATUS NOT OK");
    $finish;
  endtask
  task automatic chk(input string nm, input logic [31:0] x, input logic [31:0] s);
    checked++;
    if (s !== x) begin
      err_total++;
      $display("FAIL %s expected %h seen %h", nm, x, s);
    end
  endtask
  task automatic wait_rdy;
    int n;
    n = 0;
    do begin
      @(posedge hclk);
      n++;
    end while (hreadyout !== 1'b1 && n < 50);
    if (hreadyout !== 1'b1) begin
      err_total++;
      give_verdict();
    end
  endtask
  // One single-word bus transfer, read data left in rd
  task automatic bus(input logic [7:0] a, input logic w, input logic [31:0] x);
    haddr <= {24'h0, a};
    hwrite <= w;
    htrans <= 2'h2;
    wait_rdy();
    htrans <= 2'h0;
    hwdata <= x;
    wait_rdy();
    rd = hrdata;
  endtask
  function automatic logic [DW-1:0] fmt(input logic [DW-1:0] r, input int f, input int o);
    if (o == 1) return f ? POS_FS_BIN : POS_FS_TWOS;
    if (o == 2) return f ? NEG_FS_BIN : NEG_FS_TWOS;
    return f ? r ^ 11'h400 : r;
  endfunction
  // Configure, let the stream settle, note expected words, wait for them
  task automatic stream(input logic [6:0] c, input logic [3:0] gn, input logic [1:0] s,
                        input logic [DW-1:0] x, input logic [DW-1:0] xb);
    int n;
    bus(OFS_CTRL, 1, {25'h0, c});
    bus(OFS_GAIN, 1, {28'h0, gn});
    repeat (200) @(posedge hclk);
    q.push_back({s, x});
    if (s != 2'h2) q.push_back({2'h1, xb});
    n = 0;
    while (q.size() > 0 && n < 500) begin
      @(posedge hclk);
      n++;
    end
    if (q.size() > 0) begin
      err_total++;
      give_verdict();
    end
  endtask
  // Step input A after a sample rise, count CMOS captures until it shows; two for alignment
  task automatic lat(input int x);
    int n, n0;
    logic [DW-1:0] v;
    @(posedge sample_clk_pin);
    repeat (4) @(posedge hclk);
    v = ~raw_a;
    raw_a <= v;
    n0 = n_cm;
    for (n = 0; n < 2000 && cm_a !== v; n++) @(posedge hclk);
    if (cm_a !== v) begin
      err_total++;
      give_verdict();
    end
    chk("latency", x + 2, n_cm - n0);
  endtask
  // Compare each CMOS capture with every pending CMOS note, up to the first DDR note
  always @(n_cm) begin
    while (q.size() > 0 && q[0][12:11] != 2'h2) begin
      e = q.pop_front();
      chk("cmos", 32'(e[10:0]), 32'(e[12:11] == 0 ? cm_a : e[12:11] == 1 ? cm_b : mux_a));
    end
  end
  // Compare each captured DDR word with the oldest note, if that note is a DDR note
  always @(n_ddr) begin
    if (q.size() > 0 && q[0][12:11] == 2'h2) begin
      g = q.pop_front();
      chk("ddr", 32'(g[10:0]), 32'(ddr_a));
    end
  end
  // Main sequence
  initial begin
    repeat (5) @(posedge hclk);
    hresetn <= 1;
    @(posedge hclk);
    chk("drive_rst", 0, {28'h0, clock_drive_level, data_drive_level, lvds_current});
    for (int i = 0; i < 6; i++) begin
      bus(8'(i * 4 + (i / 5) * 44), 0, 0);
      chk("reg_rst", 0, rd);
    end
    for (int i = 0; i < 8; i++) begin
      d = 8'($random(seed));
      d = {d[7:6], i[2:0], d[2], i[1:0]};
      bus(OFS_DRIVE, 1, {24'h0, d});
      bus(OFS_DRIVE, 0, 0);
      chk("drive", {24'h0, d}, rd);
      chk("drive_pins", 32'(d), 32'({clock_drive_level, data_drive_level, termination,
          current_double, lvds_current}));
    end
    bus(OFS_DCTRL, 1, 32'h13);
    bus(OFS_DCTRL, 0, 0);
    chk("dctrl", 32'h13, rd);
    for (int f = 0; f < 2; f++) begin
      for (int k = 0; k < 3; k++) begin
        ra = 11'($random(seed));
        rb = 11'($random(seed));
        raw_a <= ra;
        raw_b <= rb;
        over_pos <= {k == 2, k == 1};
        over_neg <= {k == 1, k == 2};
        stream({5'h0, f[0], 1'b0}, 4'h0, 2'h0, fmt(ra, f, k), fmt(rb, f, (3 - k) % 3));
      end
    end
    over_pos <= 0;
    over_neg <= 0;
    raw_a <= 11'd1000;
    raw_b <= 11'h418;
    stream(7'h00, 4'ha, 2'h0, 11'h3ff, 11'h400);
    stream(7'h00, 4'hb, 2'h0, 11'd1000, 11'h418);
    lat(LAT_NORM);
    stream(7'h04, 4'ha, 2'h0, 11'h417, 11'h418);
    lat(LAT_LOW);
    ra = 11'($random(seed));
    rb = 11'($random(seed));
    raw_a <= ra;
    raw_b <= rb;
    stream(7'h01, 4'h0, 2'h2, ra, 0);
    stream(7'h03, 4'h0, 2'h2, ra ^ 11'h400, 0);
    chk("lvds_oe", 1, 32'(lvds_oe));
    pins <= 3'h7;
    serial_enable_pin <= 1;
    stream(7'h08, 4'h0, 2'h3, ra ^ 11'h400, rb ^ 11'h400);
    chk("a_oe", 0, 32'(channel_a_oe));
    chk("b_oe", 1, 32'(channel_b_oe));
    give_verdict();
  end
endmodule
`default_nettype wire
